// *** core/pdc_defines.svh ***
// constants, timing figures and codes for the port detect/classify sequencer
// Notes on behaviour
// - detection forces low, high, low port voltage steps with a small fixed current limit
// - each detection step waits a settling interval before sampling line current
// - signature valid only when rising and falling steps both meet criteria
// - successful detection starts classification automatically in every mode, no host command
// - class probe drives probe voltage, class current limit, one measurement per probe
// - lower power mode uses a single classification probe
// - higher power mode uses two classification probes
// - after detect and class succeed, power the port and monitor continuously
// - start either shut down with ports idle or autonomous sequencing
// - two selectable detection timing variants: endpoint and midspan
// - sample four address straps at power-up, then release pins for internal use
// - interrupt goes low within limit after event, releases within limit after read-clear
// - clock stretch during acknowledge never exceeds the stated maximum
// - classification begins a short typical delay after valid detection ends
// - dual-probe classification inserts a fixed mark interval between probes
// - port power turns on within the maximum time after valid detection
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

`define PDC_CLK_MHZ         200
`define PDC_PORTS           4
// timing figures in their own units
`define PDC_SETTLE_US       2000
`define PDC_SETTLE_MID_US   4000
`define PDC_CLASS_DLY_MS    5
`define PDC_CLE_MS          15
`define PDC_MARK_MS         8
`define PDC_PON_MS          400
`define PDC_INT_MS          5
`define PDC_STRETCH_US      10
// derived cycle counts
`define PDC_SETTLE_CYC      (`PDC_SETTLE_US * `PDC_CLK_MHZ)
`define PDC_SETTLE_MID_CYC  (`PDC_SETTLE_MID_US * `PDC_CLK_MHZ)
`define PDC_CLASS_DLY_CYC   (`PDC_CLASS_DLY_MS * 1000 * `PDC_CLK_MHZ)
`define PDC_CLE_CYC         (`PDC_CLE_MS * 1000 * `PDC_CLK_MHZ)
`define PDC_MARK_CYC        (`PDC_MARK_MS * 1000 * `PDC_CLK_MHZ)
`define PDC_STRETCH_CYC     (`PDC_STRETCH_US * `PDC_CLK_MHZ)
// probe voltage codes for the analog front end
`define PDC_VOLT_OFF        3'h0
`define PDC_VOLT_DET_LO     3'h1
`define PDC_VOLT_DET_HI     3'h2
`define PDC_VOLT_CLASS      3'h3
`define PDC_VOLT_MARK       3'h4
// current limit codes, then the class code for no valid class
`define PDC_ILIM_OFF        2'h0
`define PDC_ILIM_DET        2'h1
`define PDC_ILIM_CLASS      2'h2
`define PDC_ILIM_RUN        2'h3
`define PDC_CLASS_NONE      3'h7

`endif

// *** core/pdc_pkg.sv ***
// types shared by the sequencer files
package pdc_pkg;
    typedef enum logic [8:0] {
        PDC_IDLE   = 9'h001,
        PDC_DLO1   = 9'h002,
        PDC_DHI    = 9'h004,
        PDC_DLO2   = 9'h008,
        PDC_CDLY   = 9'h010,
        PDC_CLS1   = 9'h020,
        PDC_MARK   = 9'h040,
        PDC_CLS2   = 9'h080,
        PDC_ON     = 9'h100
    } pdc_state_t;
endpackage : pdc_pkg

// *** core/pdc_port_seq.sv ***
// one port's detect, classify and power-on sequencer
`timescale 1ns/1ps
`include "pdc_defines.svh"
module pdc_port_seq #(
    parameter int unsigned SETTLE_CYC     = `PDC_SETTLE_CYC,
    parameter int unsigned SETTLE_MID_CYC = `PDC_SETTLE_MID_CYC,
    parameter int unsigned CDLY_CYC       = `PDC_CLASS_DLY_CYC,
    parameter int unsigned CLE_CYC        = `PDC_CLE_CYC,
    parameter int unsigned MARK_CYC       = `PDC_MARK_CYC
) (
    input  wire logic       clk,           // core clock
    input  wire logic       rst_n,         // synchronised reset
    input  wire logic       enable,        // port may sequence
    input  wire logic       highPower,     // 1 = two-probe classification
    input  wire logic       midspanTiming, // 1 = midspan detection timing
    input  wire logic       sigOk,         // comparator: signature current in range
    input  wire logic [2:0] classMeas,     // measured class of current probe
    input  wire logic       portFault,     // monitor drops power
    output logic      [2:0] voltSel,       // requested probe voltage
    output logic      [1:0] ilimSel,       // requested current limit
    output logic            powerOn,       // port fet on
    output logic            measStrobe,    // one-cycle sample of line current
    output logic            evtPulse,      // outcome event
    output logic            detValid,      // last detection result
    output logic      [2:0] classOut       // last class
);
    pdc_pkg::pdc_state_t stateFf, nxtState;
    logic [31:0] cntFf;
    logic        riseOkFf, loOkFf;
    logic [2:0]  cls1Ff;

    wire [31:0] settleLen = midspanTiming ? SETTLE_MID_CYC : SETTLE_CYC;
    wire [31:0] curLen =
        (stateFf == pdc_pkg::PDC_CDLY) ? CDLY_CYC :
        (stateFf == pdc_pkg::PDC_MARK) ? MARK_CYC :
        (stateFf == pdc_pkg::PDC_CLS1 || stateFf == pdc_pkg::PDC_CLS2) ? CLE_CYC :
        settleLen;
    wire stepDone = (cntFf == curLen - 32'h1);
    wire inTimed  = (stateFf != pdc_pkg::PDC_IDLE) && (stateFf != pdc_pkg::PDC_ON);
    wire sigValid = riseOkFf && loOkFf && sigOk;
    wire classOk  = (classMeas != `PDC_CLASS_NONE);

    // next state
    always_comb begin
        nxtState = stateFf;
        unique case (stateFf)
            pdc_pkg::PDC_IDLE: if (enable) nxtState = pdc_pkg::PDC_DLO1;
            pdc_pkg::PDC_DLO1: if (stepDone) nxtState = pdc_pkg::PDC_DHI;
            pdc_pkg::PDC_DHI:  if (stepDone) nxtState = pdc_pkg::PDC_DLO2;
            pdc_pkg::PDC_DLO2: if (stepDone)
                nxtState = sigValid ? pdc_pkg::PDC_CDLY : pdc_pkg::PDC_IDLE;
            pdc_pkg::PDC_CDLY: if (stepDone) nxtState = pdc_pkg::PDC_CLS1;
            pdc_pkg::PDC_CLS1: if (stepDone) begin
                if (!classOk) nxtState = pdc_pkg::PDC_IDLE;
                else if (highPower) nxtState = pdc_pkg::PDC_MARK;
                else nxtState = pdc_pkg::PDC_ON;
            end
            pdc_pkg::PDC_MARK: if (stepDone) nxtState = pdc_pkg::PDC_CLS2;
            pdc_pkg::PDC_CLS2: if (stepDone)
                nxtState = classOk ? pdc_pkg::PDC_ON : pdc_pkg::PDC_IDLE;
            pdc_pkg::PDC_ON:   if (!enable || portFault) nxtState = pdc_pkg::PDC_IDLE;
            default:           nxtState = pdc_pkg::PDC_IDLE;
        endcase
        if (!enable && stateFf != pdc_pkg::PDC_ON) nxtState = pdc_pkg::PDC_IDLE;
    end

    // probe drive follows the state, so it is glitch-free from flops
    wire [2:0] nxtVolt =
        (nxtState == pdc_pkg::PDC_DHI) ? `PDC_VOLT_DET_HI :
        (nxtState == pdc_pkg::PDC_DLO1 || nxtState == pdc_pkg::PDC_DLO2) ? `PDC_VOLT_DET_LO :
        (nxtState == pdc_pkg::PDC_CLS1 || nxtState == pdc_pkg::PDC_CLS2) ? `PDC_VOLT_CLASS :
        (nxtState == pdc_pkg::PDC_MARK) ? `PDC_VOLT_MARK : `PDC_VOLT_OFF;
    wire [1:0] nxtIlim =
        (nxtState == pdc_pkg::PDC_ON) ? `PDC_ILIM_RUN :
        (nxtVolt == `PDC_VOLT_DET_LO || nxtVolt == `PDC_VOLT_DET_HI) ? `PDC_ILIM_DET :
        (nxtVolt == `PDC_VOLT_OFF) ? `PDC_ILIM_OFF : `PDC_ILIM_CLASS;
    wire sampleNow = inTimed && stepDone && (stateFf != pdc_pkg::PDC_CDLY) &&
                     (stateFf != pdc_pkg::PDC_MARK);
    wire endDetFail = (stateFf == pdc_pkg::PDC_DLO2) && stepDone && !sigValid;
    wire enterOn   = (nxtState == pdc_pkg::PDC_ON) && (stateFf != pdc_pkg::PDC_ON);
    wire classFail = (stateFf == pdc_pkg::PDC_CLS1 || stateFf == pdc_pkg::PDC_CLS2) &&
                     stepDone && !classOk;
    wire dropOn    = (stateFf == pdc_pkg::PDC_ON) && (nxtState == pdc_pkg::PDC_IDLE);

    // state and step counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateFf <= pdc_pkg::PDC_IDLE;
            cntFf   <= 32'h0;
        end else begin
            stateFf <= nxtState;
            cntFf   <= (nxtState != stateFf || !inTimed) ? 32'h0 : cntFf + 32'h1;
        end
    end

    // per-step capture of the detection and class samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            riseOkFf <= 1'b0;
            loOkFf   <= 1'b0;
            cls1Ff   <= 3'h0;
        end else if (sampleNow) begin
            if (stateFf == pdc_pkg::PDC_DLO1) loOkFf <= sigOk;
            if (stateFf == pdc_pkg::PDC_DHI) riseOkFf <= sigOk && loOkFf;
            if (stateFf == pdc_pkg::PDC_CLS1) cls1Ff <= classMeas;
        end
    end

    // outputs, all registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            voltSel    <= `PDC_VOLT_OFF;
            ilimSel    <= `PDC_ILIM_OFF;
            powerOn    <= 1'b0;
            measStrobe <= 1'b0;
            evtPulse   <= 1'b0;
            detValid   <= 1'b0;
            classOut   <= 3'h0;
        end else begin
            voltSel    <= nxtVolt;
            ilimSel    <= nxtIlim;
            powerOn    <= (nxtState == pdc_pkg::PDC_ON);
            measStrobe <= sampleNow;
            evtPulse   <= endDetFail || enterOn || classFail || dropOn;
            if (stateFf == pdc_pkg::PDC_DLO2 && stepDone) detValid <= sigValid;
            if (enterOn) classOut <= highPower ? cls1Ff : classMeas;
        end
    end
endmodule : pdc_port_seq

// *** core/pdc_port_ctrl.sv ***
// four-port sequencer top with strap capture, interrupt and clock stretch
`timescale 1ns/1ps
`include "pdc_defines.svh"
module pdc_port_ctrl #(
    parameter int unsigned SETTLE_CYC     = `PDC_SETTLE_CYC,
    parameter int unsigned SETTLE_MID_CYC = `PDC_SETTLE_MID_CYC,
    parameter int unsigned CDLY_CYC       = `PDC_CLASS_DLY_CYC,
    parameter int unsigned CLE_CYC        = `PDC_CLE_CYC,
    parameter int unsigned MARK_CYC       = `PDC_MARK_CYC,
    parameter int unsigned STRETCH_CYC    = `PDC_STRETCH_CYC
) (
    input  wire logic        core_clk,        // 200 MHz clock
    input  wire logic        arst_n,          // async reset, active low
    input  wire logic        autoMode,        // 1 = autonomous start, 0 = shutdown
    input  wire logic [3:0]  hostPortEn,      // host enables in shutdown mode
    input  wire logic [3:0]  highPower,       // per port two-probe mode
    input  wire logic        midspanTiming,   // detection timing variant
    input  wire logic [3:0]  sigOk,           // per port signature comparator
    input  wire logic [11:0] classMeas,       // per port measured class, 3 bits each
    input  wire logic [3:0]  portFault,       // per port monitor fault
    input  wire logic        addr_strap_bit0, // strap pin input 0
    input  wire logic        addr_strap_bit1, // strap pin input 1
    input  wire logic        addr_strap_bit2, // strap pin input 2
    input  wire logic        addr_strap_bit3, // strap pin input 3
    input  wire logic        statusRead,      // one-cycle clear-on-read of status
    input  wire logic        ackNeedsTime,    // bus slave wants to stretch in ack
    input  wire logic        inAckPhase,      // bus is in its acknowledge slot
    output logic [3:0]       busAddr,         // captured strap address
    output logic             addrValid,       // straps captured, pins released
    output logic             intOut,          // interrupt pin drive level
    output logic             intOe,           // interrupt open-drain enable
    output logic             sclOut,          // clock pin drive level
    output logic             sclOe,           // clock stretch enable
    output logic [3:0]       statusEvt,       // sticky outcome per port
    output logic [11:0]      voltSel,         // probe voltage codes
    output logic [7:0]       ilimSel,         // current limit codes
    output logic [3:0]       powerOn,         // port power
    output logic [3:0]       measStrobe,      // line current sample strobes
    output logic [3:0]       detValid,        // last detection result
    output logic [11:0]      classOut         // last class per port
);
    logic rstMetaFf, rstSyncFf;
    logic [31:0] stretchCntFf;
    logic [3:0] evt;

    // reset release through two flops; the tail drives everything else
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMetaFf <= 1'b0;
            rstSyncFf <= 1'b0;
        end else begin
            rstMetaFf <= 1'b1;
            rstSyncFf <= rstMetaFf;
        end
    end
    wire rstN = rstSyncFf;

    // straps caught once after release; later pin activity is ignored
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            busAddr   <= 4'h0;
            addrValid <= 1'b0;
        end else if (!addrValid) begin
            busAddr   <= {addr_strap_bit3, addr_strap_bit2,
                          addr_strap_bit1, addr_strap_bit0};
            addrValid <= 1'b1;
        end
    end

    // auto mode sequences all ports; shutdown waits for the host
    wire [3:0] portEn = autoMode ? 4'hF : hostPortEn;

    genvar p;
    generate
        for (p = 0; p < `PDC_PORTS; p++) begin : gPort
            pdc_port_seq #(
                .SETTLE_CYC     (SETTLE_CYC),
                .SETTLE_MID_CYC (SETTLE_MID_CYC),
                .CDLY_CYC       (CDLY_CYC),
                .CLE_CYC        (CLE_CYC),
                .MARK_CYC       (MARK_CYC)
            ) uSeq (
                .clk           (core_clk),
                .rst_n         (rstN),
                .enable        (portEn[p] && addrValid),
                .highPower     (highPower[p]),
                .midspanTiming (midspanTiming),
                .sigOk         (sigOk[p]),
                .classMeas     (classMeas[3*p +: 3]),
                .portFault     (portFault[p]),
                .voltSel       (voltSel[3*p +: 3]),
                .ilimSel       (ilimSel[2*p +: 2]),
                .powerOn       (powerOn[p]),
                .measStrobe    (measStrobe[p]),
                .evtPulse      (evt[p]),
                .detValid      (detValid[p]),
                .classOut      (classOut[3*p +: 3])
            );
        end
    endgenerate

    // sticky status; a new event beats a simultaneous read-clear
    wire [3:0] nxtStatus = evt | (statusRead ? 4'h0 : statusEvt);
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            statusEvt <= 4'h0;
            intOe     <= 1'b0;
        end else begin
            statusEvt <= nxtStatus;
            intOe     <= |nxtStatus;   // low one cycle after event, released one cycle after clear
        end
    end

    // stretch only in the ack slot, capped two cycles inside the limit;
    // the running cycle is counted too, so the cap is never overshot by one
    wire stretchOk = ackNeedsTime && inAckPhase &&
                     (stretchCntFf + {31'h0, sclOe} < STRETCH_CYC - 32'h2);
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            stretchCntFf <= 32'h0;
            sclOe        <= 1'b0;
        end else begin
            stretchCntFf <= inAckPhase ? stretchCntFf + {31'h0, sclOe} : 32'h0;
            sclOe        <= stretchOk;
        end
    end

    // open-drain pins only ever drive low
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            intOut <= 1'b0;
            sclOut <= 1'b0;
        end else begin
            intOut <= 1'b0;
            sclOut <= 1'b0;
        end
    end
endmodule : pdc_port_ctrl

// *** sim/pdc_port_ctrl_properties.sv ***
// concurrent checks on the four-port sequencer top, bound to its ports
`timescale 1ns/1ps
module pdc_port_ctrl_checker #(
    parameter int unsigned STRETCH_CYC = 20
) (
    input wire logic        core_clk,   // core clock
    input wire logic        arst_n,     // async reset, active low
    input wire logic        autoMode,   // autonomous start
    input wire logic [3:0]  hostPortEn, // host port enables
    input wire logic [3:0]  highPower,  // two-probe mode per port
    input wire logic        inAckPhase, // bus acknowledge slot
    input wire logic [3:0]  busAddr,    // captured strap address
    input wire logic        addrValid,  // straps captured
    input wire logic        intOut,     // interrupt drive level
    input wire logic        intOe,      // interrupt enable
    input wire logic        sclOe,      // clock stretch enable
    input wire logic [3:0]  statusEvt,  // sticky outcome events
    input wire logic [11:0] voltSel,    // probe voltage codes
    input wire logic [7:0]  ilimSel,    // current limit codes
    input wire logic [3:0]  powerOn     // port power
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    logic [7:0] stretchLen_ff;
    // length of the running stretch; a stuck enable would hang the host's bus
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) stretchLen_ff <= 8'h00;
        else stretchLen_ff <= sclOe ? stretchLen_ff + 8'h01 : 8'h00;
    end
    // port 0 stands for all four, though the bench gives each port its own settings
    property p_det_limit; (voltSel[2:0] inside {3'h1, 3'h2}) |-> ilimSel[1:0] == 2'h1; endproperty
    a_det_limit: assert property (p_det_limit) else $error("detect step without detect limit");
    property p_det_order; $rose(voltSel[2:0] == 3'h2) |-> $past(voltSel[2:0]) == 3'h1; endproperty
    a_det_order: assert property (p_det_order) else $error("high step not after low step");
    property p_settle; $rose(voltSel[2:0] == 3'h2) |-> (voltSel[2:0] == 3'h2)[*8]; endproperty
    a_settle: assert property (p_settle) else $error("detect step cut short");
    property p_class_limit; voltSel[2:0] == 3'h3 |-> ilimSel[1:0] == 2'h2; endproperty
    a_class_limit: assert property (p_class_limit) else $error("class probe wrong limit");
    property p_single; !highPower[0] && $fell(voltSel[2:0] == 3'h3) |-> voltSel[2:0] != 3'h4;
    endproperty
    a_single: assert property (p_single) else $error("mark seen in single probe mode");
    property p_mark; $rose(voltSel[2:0] == 3'h4) |-> highPower[0] ##1 (voltSel[2:0] == 3'h4)[*6];
    endproperty
    a_mark: assert property (p_mark) else $error("mark interval wrong");
    property p_power; $rose(powerOn[0]) |-> $past(voltSel[2:0]) == 3'h3; endproperty
    a_power: assert property (p_power) else $error("power on without class probe");
    property p_shutdown; (!autoMode && !hostPortEn[0])[*3] |-> voltSel[2:0] == 3'h0 && !powerOn[0];
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("disabled port not idle");
    property p_addr_hold; $past(addrValid) |-> addrValid && $stable(busAddr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("strap address changed");
    property p_int_set; (|statusEvt) |-> ##[0:2] intOe; endproperty
    a_int_set: assert property (p_int_set) else $error("interrupt late");
    property p_int_clr; (statusEvt == 4'h0)[*2] |-> !intOe; endproperty
    a_int_clr: assert property (p_int_clr) else $error("interrupt not released");
    property p_int_low; intOe |-> !intOut; endproperty
    a_int_low: assert property (p_int_low) else $error("interrupt drives high");
    property p_stretch_cap; stretchLen_ff <= STRETCH_CYC - 2; endproperty
    a_stretch_cap: assert property (p_stretch_cap) else $error("stretch too long");
    property p_stretch_ack; $rose(sclOe) |-> inAckPhase || $past(inAckPhase); endproperty
    a_stretch_ack: assert property (p_stretch_ack) else $error("stretch outside ack");
endmodule : pdc_port_ctrl_checker
bind pdc_port_ctrl pdc_port_ctrl_checker #(.STRETCH_CYC(STRETCH_CYC)) pdc_port_ctrl_checker_inst (
    .core_clk(core_clk), .arst_n(arst_n), .autoMode(autoMode), .hostPortEn(hostPortEn),
    .highPower(highPower), .inAckPhase(inAckPhase), .busAddr(busAddr), .addrValid(addrValid),
    .intOut(intOut), .intOe(intOe), .sclOe(sclOe), .statusEvt(statusEvt), .voltSel(voltSel),
    .ilimSel(ilimSel), .powerOn(powerOn));

// *** sim/pdc_pd_model.sv ***
// powered device stand-in on each port: answers detection and class probes
`timescale 1ns/1ps
module pdc_pd_model (
    input  wire logic        clk,      // core clock
    input  wire logic [11:0] voltSel,  // probe voltage per port
    input  wire logic [3:0]  sigGood,  // device shows a valid signature
    input  wire logic [3:0]  badFall,  // signature fails on the falling step
    input  wire logic [11:0] cls,      // class each device draws
    output logic      [3:0]  sigOk,    // signature comparator per port
    output logic      [11:0] classMeas // measured class per port
);
    logic [3:0] seenHi = 4'h0;
    logic [3:0] junk   = 4'h5;
    // outside a probe the line floats, so show a toggling pattern rather than a held value
    always @(posedge clk) begin
        junk <= ~junk;
        for (int p = 0; p < 4; p++) begin
            if (voltSel[3*p+:3] == 3'h2) seenHi[p] <= 1'b1;
            else if (voltSel[3*p+:3] != 3'h1) seenHi[p] <= 1'b0;
        end
    end
    // signature current on each detect step, class current during a class probe
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            sigOk[p] = junk[p];
            classMeas[3*p+:3] = {3{junk[p]}};
            if (voltSel[3*p+:3] inside {3'h1, 3'h2})
                sigOk[p] = sigGood[p] && !(badFall[p] && seenHi[p] && voltSel[3*p+:3] == 3'h1);
            if (voltSel[3*p+:3] == 3'h3) classMeas[3*p+:3] = cls[3*p+:3];
        end
    end
endmodule : pdc_pd_model

// *** sim/tb_pdc_port_ctrl.sv ***
// self-checking bench for the four-port detect, classify and power-on sequencer
`timescale 1ns/1ps
module tb_pdc_port_ctrl;
    localparam int ST = 10, SM = 20, CD = 10, CL = 10, MK = 8, SC = 20;
    logic core_clk, arst_n, autoMode, midspanTiming, statusRead, ackNeedsTime, inAckPhase;
    logic addrValid, intOut, intOe, sclOut, sclOe;
    logic [3:0] hostPortEn, highPower, portFault, straps, sigOk, sigGood, badFall, addrExp, expOn;
    logic [3:0] busAddr, statusEvt, powerOn, detValid, measStrobe;
    logic [11:0] classMeas, cls, voltSel, classOut;
    logic [7:0] ilimSel;
    logic [2:0] prevV[4];
    int errors, checks_done, cyc, n, seed;
    int probes[4], dloCnt[4], waitCnt[4], strobes[4];
    pdc_port_ctrl #(.SETTLE_CYC(ST), .SETTLE_MID_CYC(SM), .CDLY_CYC(CD), .CLE_CYC(CL),
        .MARK_CYC(MK), .STRETCH_CYC(SC)) pdc_port_ctrl_inst (.core_clk(core_clk),
        .arst_n(arst_n), .autoMode(autoMode), .hostPortEn(hostPortEn), .highPower(highPower),
        .midspanTiming(midspanTiming), .sigOk(sigOk), .classMeas(classMeas),
        .portFault(portFault), .addr_strap_bit0(straps[0]), .addr_strap_bit1(straps[1]),
        .addr_strap_bit2(straps[2]), .addr_strap_bit3(straps[3]), .statusRead(statusRead),
        .ackNeedsTime(ackNeedsTime), .inAckPhase(inAckPhase), .busAddr(busAddr),
        .addrValid(addrValid), .intOut(intOut), .intOe(intOe), .sclOut(sclOut), .sclOe(sclOe),
        .statusEvt(statusEvt), .voltSel(voltSel), .ilimSel(ilimSel), .powerOn(powerOn),
        .measStrobe(measStrobe), .detValid(detValid), .classOut(classOut));
    pdc_pd_model pdc_pd_model_inst (.clk(core_clk), .voltSel(voltSel), .sigGood(sigGood),
        .badFall(badFall), .cls(cls), .sigOk(sigOk), .classMeas(classMeas));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (exp !== got) begin
            errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // a hang counts as a mismatch and still reaches the report
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            conclude();
        end
    end
    // reference model per port, sampled on the falling edge where outputs have settled
    always @(negedge core_clk) begin
        for (int p = 0; p < 4; p++) begin
            waitCnt[p]++;
            if (voltSel[3*p+:3] == 3'h1 && prevV[p] == 3'h0) probes[p] = 0;
            if (voltSel[3*p+:3] == 3'h1 && prevV[p] == 3'h0) strobes[p] = 0;
            if (measStrobe[p] === 1'b1) strobes[p]++;
            if (voltSel[3*p+:3] == 3'h1 && prevV[p] == 3'h0) dloCnt[p] = 0;
            if (voltSel[3*p+:3] == 3'h1) dloCnt[p]++;
            if (voltSel[3*p+:3] == 3'h0 && prevV[p] == 3'h1) waitCnt[p] = 0;
            if (voltSel[3*p+:3] == 3'h2 && prevV[p] == 3'h1)
                check("settle", 1, dloCnt[p] >= (midspanTiming ? SM : ST) && dloCnt[p] <= (midspanTiming ? SM : ST) + 1);
            if (voltSel[3*p+:3] == 3'h3 && prevV[p] == 3'h0)
                check("class delay", 1, waitCnt[p] >= CD - 1 && waitCnt[p] <= CD + 2);
            if (voltSel[3*p+:3] == 3'h3 && prevV[p] != 3'h3) probes[p]++;
            if (powerOn[p] && waitCnt[p] >= 0 && prevV[p] == 3'h3) begin
                check("probes", highPower[p] ? 2 : 1, probes[p]);
                check("strobes", highPower[p] ? 5 : 4, strobes[p]);
                check("classOut", cls[3*p+:3], classOut[3*p+:3]);
                check("detValid", 1, detValid[p]);
                check("power time", 1, waitCnt[p] <= CD + 2 * CL + MK + 6);
            end
            prevV[p] = voltSel[3*p+:3];
        end
    end
    initial begin
        seed = 32'h3DE1;
        {autoMode, midspanTiming, statusRead, ackNeedsTime, inAckPhase} = 5'h00;
        {hostPortEn, highPower, portFault, sigGood, badFall} = 20'h00000;
        cls = 12'h000;
        straps = 4'($random(seed));
        addrExp = straps;
        arst_n = 1'b0;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk) arst_n = 1'b1;
        repeat (5) @(negedge core_clk);
        check("busAddr", addrExp, {addrValid, busAddr} & 5'h0F);
        check("addrValid", 1, addrValid);
        straps = ~straps;
        repeat (40) @(negedge core_clk);
        check("busAddr held", addrExp, busAddr);
        check("idle ports", 0, {voltSel, powerOn});
        for (int r = 0; r < 4; r++) begin
            highPower = 4'($random(seed));
            for (int p = 0; p < 4; p++) cls[3*p+:3] = 3'($unsigned($random(seed)) % 5);
            sigGood = 4'hF;
            badFall = (r == 1) ? 4'h5 : 4'h0;
            midspanTiming = r[0];
            hostPortEn = (r == 2) ? 4'h6 : 4'h0;
            autoMode = (r != 2);
            expOn = sigGood & ~badFall & (autoMode ? 4'hF : hostPortEn);
            for (int t = 0; t < 500 && powerOn !== expOn; t++) @(negedge core_clk);
            repeat (3) @(negedge core_clk);
            check("powerOn", expOn, powerOn);
            check("failed detect", 0, detValid & badFall);
            check("event", 1, (|statusEvt) && intOe);
            // disable only while port 0 is between steps, so no port 0 detect step is cut
            for (int t = 0; t < 100 && voltSel[2:0] !== 3'h0; t++) @(negedge core_clk);
            portFault = 4'hF;
            autoMode = 1'b0;
            hostPortEn = 4'h0;
            @(negedge core_clk) portFault = 4'h0;
            repeat (3) @(negedge core_clk);
            check("power dropped", 0, powerOn);
            statusRead = 1'b1;
            @(negedge core_clk) statusRead = 1'b0;
            repeat (3) @(negedge core_clk);
            check("cleared", 0, {statusEvt, intOe});
        end
        inAckPhase = 1'b1;
        ackNeedsTime = 1'b1;
        n = 0;
        repeat (40) begin
            @(negedge core_clk);
            n = n + int'(sclOe === 1'b1);
        end
        check("stretch", 1, n > 0 && n <= SC - 2 && sclOut === 1'b0);
        conclude();
    end
endmodule : tb_pdc_port_ctrl
